// ==== rtl/dcls_pkg.sv ====
// dcls_pkg: geometry, offsets, reset values and types of the data cache line state control
// assumes one 100 MHz clock and a synchronous active-high reset
package dcls_pkg;
  // ***********************************************
  // geometry and encodings
  // ***********************************************
  localparam int          WAYS      = 4;
  localparam int          SETS      = 4;
  localparam int          TAG_W     = 26;
  localparam logic [1:0]  SNP_LEAVE = 2'h1;
  localparam logic [1:0]  SNP_INV   = 2'h2;
  localparam logic [7:0]  LFSR_RST  = 8'h5A;
  localparam logic [15:0] CNT_STEP  = 16'h0001;
  // register offsets
  localparam logic [7:0]  REG_SEED   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_HITS   = 8'h08;
  localparam logic [7:0]  REG_MISSES = 8'h0C;

  // ***********************************************
  // types
  // ***********************************************
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_CACHE_INVALIDATE, OP_CACHE_PUSH} dcls_op_t;
  typedef enum logic [1:0] {MEM_IDLE, MEM_LINE_RD, MEM_LINE_WR, MEM_WORD_WR} dcls_mem_t;
  typedef enum logic [1:0] {S_IDLE, S_FILL, S_PUSH, S_WT} dcls_fsm_t;

  typedef struct packed {
    logic              valid;
    logic [3:0]        longword_dirty_bits;
    logic [TAG_W-1:0]  tag;
    logic [127:0]      data;
  } dcls_line_t;

  typedef struct packed {
    dcls_op_t     op;
    logic         page_cache_mode_field;
    logic [31:0]  addr;
    logic [31:0]  wdata;
    logic [3:0]   be;
  } dcls_cpu_req_t;

  typedef struct packed {
    logic         we;
    logic [1:0]   code;
    logic         full_line;
    logic [31:0]  addr;
    logic [31:0]  wdata;
    logic [3:0]   be;
  } dcls_snp_req_t;

  typedef struct packed {
    dcls_line_t [WAYS-1:0][SETS-1:0] lines;
    dcls_fsm_t      fsm;
    dcls_cpu_req_t  req;
    logic [1:0]     way;
    logic           pb_valid;
    logic [27:0]    pb_lineaddr;
    logic [127:0]   pb_data;
    logic [7:0]     lfsr;
    logic           mem_req;
    dcls_mem_t      mem_cmd;
    logic [31:0]    mem_addr;
    logic [127:0]   mem_wline;
    logic [31:0]    mem_wword;
    logic [3:0]     mem_be;
    logic           cpu_done;
    logic [31:0]    cpu_rdata;
    logic           snp_done;
    logic           snp_inhibit;
    logic [127:0]   snp_rline;
    logic [31:0]    rd_data;
    logic [15:0]    hits;
    logic [15:0]    misses;
  } dcls_state_t;
endpackage : dcls_pkg

// ==== rtl/dcls_core.sv ====
// dcls_core: line state control of a four-way data cache with push buffer and snooping
// assumes memory answers each held request with a one-cycle mem_ack on sys_clk
//
// Functional notes
// - each line invalid, valid or dirty only
// - page mode selects write-through or copyback
// - read or copyback write miss fetches line
// - allocation prefers an invalid way
// - full set: pseudo-random way replaced
// - dirty victim buffered, written after fill
// - snoops also check the push buffer
// - read hit returns data, state kept
// - read miss ends valid, victim pushed later
// - copyback write miss fills, merges, marks dirty
// - write-through miss writes memory only
// - copyback write hit sets longword dirty bits
// - write-through hit updates cache and memory
// - invalidate drops line; push writes first
// - snoop read code 01 keeps state
// - snoop read code 10 invalidates line
// - other snoop write hits invalidate line
// - snoop partial write code 01 sinks dirty
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module dcls_core (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  // integer_unit requests
  input  wire logic                    cpu_req,
  input  wire dcls_pkg::dcls_cpu_req_t cpu_cmd,
  output logic                         cpu_ready,
  output logic                         cpu_done,
  output logic [31:0]                  cpu_rdata,
  // memory side
  output logic                         mem_req,
  output dcls_pkg::dcls_mem_t          mem_cmd,
  output logic [31:0]                  mem_addr,
  output logic [127:0]                 mem_wline,
  output logic [31:0]                  mem_wword,
  output logic [3:0]                   mem_be,
  input  wire logic                    mem_ack,
  input  wire logic [127:0]            mem_rline,
  // snoop side
  input  wire logic                    snp_valid,
  input  wire dcls_pkg::dcls_snp_req_t snp_cmd,
  output logic                         snp_done,
  output logic                         snp_inhibit,
  output logic [127:0]                 snp_rline,
  // register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [31:0]                  reg_rdata
);
  // ***********************************************
  // state
  // ***********************************************
  dcls_pkg::dcls_state_t st_q;
  dcls_pkg::dcls_state_t st_d;
  logic                  cpu_taken;
  logic                  c_hit;
  logic [1:0]            c_way;
  logic [1:0]            c_idx;
  logic [31:0]           c_word;
  logic                  s_hit;
  logic [1:0]            s_way;
  logic [1:0]            s_idx;
  logic                  s_act;
  logic                  pb_hit;
  logic                  v_free;
  logic [1:0]            v_way;

  function automatic logic [31:0] merge_word(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_word

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    st_d             = st_q;
    st_d.cpu_done    = 1'b0;
    st_d.snp_done    = 1'b0;
    st_d.snp_inhibit = 1'b0;
    st_d.lfsr        = {st_q.lfsr[6:0], st_q.lfsr[7] ^ st_q.lfsr[5] ^ st_q.lfsr[4] ^ st_q.lfsr[3]};

    // registers
    if (reg_wr && reg_addr == dcls_pkg::REG_SEED) begin
      st_d.lfsr = (|reg_wdata[7:0]) ? reg_wdata[7:0] : dcls_pkg::LFSR_RST;
    end
    st_d.rd_data = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        dcls_pkg::REG_SEED:   st_d.rd_data = {24'h0, st_q.lfsr};
        dcls_pkg::REG_STATUS: st_d.rd_data = {29'h0, st_q.pb_valid, st_q.fsm};
        dcls_pkg::REG_HITS:   st_d.rd_data = {16'h0, st_q.hits};
        dcls_pkg::REG_MISSES: st_d.rd_data = {16'h0, st_q.misses};
        default:              st_d.rd_data = 32'h0;
      endcase
    end

    // snoop lookup in arrays and push buffer
    s_idx = snp_cmd.addr[5:4];
    s_hit = 1'b0;
    s_way = 2'h0;
    for (int w = 0; w < dcls_pkg::WAYS; w++) begin
      if (st_q.lines[w][s_idx].valid && st_q.lines[w][s_idx].tag == snp_cmd.addr[31:6]) begin
        s_hit = 1'b1;
        s_way = w[1:0];
      end
    end
    s_act  = snp_valid && (snp_cmd.code == dcls_pkg::SNP_LEAVE || snp_cmd.code == dcls_pkg::SNP_INV);
    pb_hit = st_q.pb_valid && st_q.pb_lineaddr == snp_cmd.addr[31:4] &&
             !(st_q.fsm == dcls_pkg::S_PUSH && mem_ack);
    if (snp_valid) begin
      st_d.snp_done = 1'b1;
    end
    if (s_act && s_hit) begin
      if (!snp_cmd.we) begin
        if (|st_q.lines[s_way][s_idx].longword_dirty_bits) begin
          st_d.snp_inhibit = 1'b1;
          st_d.snp_rline   = st_q.lines[s_way][s_idx].data;
        end
        if (snp_cmd.code == dcls_pkg::SNP_INV) begin
          st_d.lines[s_way][s_idx].valid               = 1'b0;
          st_d.lines[s_way][s_idx].longword_dirty_bits = 4'h0;
        end
      end else if ((|st_q.lines[s_way][s_idx].longword_dirty_bits) && snp_cmd.code == dcls_pkg::SNP_LEAVE &&
                   !snp_cmd.full_line) begin
        st_d.snp_inhibit = 1'b1;
        st_d.lines[s_way][s_idx].data[snp_cmd.addr[3:2]*32 +: 32] =
          merge_word(st_q.lines[s_way][s_idx].data[snp_cmd.addr[3:2]*32 +: 32], snp_cmd.wdata, snp_cmd.be);
        st_d.lines[s_way][s_idx].longword_dirty_bits[snp_cmd.addr[3:2]] = 1'b1;
      end else begin
        st_d.lines[s_way][s_idx].valid               = 1'b0;
        st_d.lines[s_way][s_idx].longword_dirty_bits = 4'h0;
      end
    end else if (s_act && pb_hit) begin
      if (!snp_cmd.we) begin
        st_d.snp_inhibit = 1'b1;
        st_d.snp_rline   = st_q.pb_data;
        if (snp_cmd.code == dcls_pkg::SNP_INV) begin
          st_d.pb_valid = 1'b0;
        end
      end else if (snp_cmd.code == dcls_pkg::SNP_LEAVE && !snp_cmd.full_line) begin
        st_d.snp_inhibit = 1'b1;
        st_d.pb_data[snp_cmd.addr[3:2]*32 +: 32] =
          merge_word(st_q.pb_data[snp_cmd.addr[3:2]*32 +: 32], snp_cmd.wdata, snp_cmd.be);
      end else begin
        st_d.pb_valid = 1'b0;
      end
    end
    if (st_q.fsm == dcls_pkg::S_PUSH) begin
      st_d.mem_wline = st_d.pb_data;
    end

    // processor lookup
    cpu_ready = st_q.fsm == dcls_pkg::S_IDLE && !snp_valid;
    cpu_taken = cpu_req && cpu_ready;
    c_idx     = cpu_cmd.addr[5:4];
    c_hit     = 1'b0;
    c_way     = 2'h0;
    v_free    = 1'b0;
    v_way     = st_q.lfsr[1:0];
    for (int w = dcls_pkg::WAYS - 1; w >= 0; w--) begin
      if (st_q.lines[w][c_idx].valid && st_q.lines[w][c_idx].tag == cpu_cmd.addr[31:6]) begin
        c_hit = 1'b1;
        c_way = w[1:0];
      end
      if (!st_q.lines[w][c_idx].valid) begin
        v_free = 1'b1;
        v_way  = w[1:0];
      end
    end
    c_word = st_q.lines[c_way][c_idx].data[cpu_cmd.addr[3:2]*32 +: 32];

    unique case (st_q.fsm)
      dcls_pkg::S_IDLE: begin
        if (cpu_taken) begin
          st_d.req = cpu_cmd;
          if (c_hit && cpu_cmd.op == dcls_pkg::OP_READ) begin
            st_d.cpu_done  = 1'b1;
            st_d.cpu_rdata = c_word;
            st_d.hits      = st_q.hits + dcls_pkg::CNT_STEP;
          end else if (c_hit && cpu_cmd.op == dcls_pkg::OP_WRITE) begin
            st_d.hits = st_q.hits + dcls_pkg::CNT_STEP;
            st_d.lines[c_way][c_idx].data[cpu_cmd.addr[3:2]*32 +: 32] =
              merge_word(c_word, cpu_cmd.wdata, cpu_cmd.be);
            if (cpu_cmd.page_cache_mode_field) begin
              st_d.lines[c_way][c_idx].longword_dirty_bits[cpu_cmd.addr[3:2]] = 1'b1;
              st_d.cpu_done = 1'b1;
            end else begin
              st_d.mem_req   = 1'b1;
              st_d.mem_cmd   = dcls_pkg::MEM_WORD_WR;
              st_d.mem_addr  = cpu_cmd.addr;
              st_d.mem_wword = cpu_cmd.wdata;
              st_d.mem_be    = cpu_cmd.be;
              st_d.fsm       = dcls_pkg::S_WT;
            end
          end else if (cpu_cmd.op == dcls_pkg::OP_CACHE_INVALIDATE || cpu_cmd.op == dcls_pkg::OP_CACHE_PUSH) begin
            if (c_hit && cpu_cmd.op == dcls_pkg::OP_CACHE_PUSH &&
                (|st_q.lines[c_way][c_idx].longword_dirty_bits)) begin
              st_d.pb_valid    = 1'b1;
              st_d.pb_lineaddr = cpu_cmd.addr[31:4];
              st_d.pb_data     = st_q.lines[c_way][c_idx].data;
              st_d.mem_req     = 1'b1;
              st_d.mem_cmd     = dcls_pkg::MEM_LINE_WR;
              st_d.mem_addr    = {cpu_cmd.addr[31:4], 4'h0};
              st_d.mem_wline   = st_q.lines[c_way][c_idx].data;
              st_d.fsm         = dcls_pkg::S_PUSH;
            end else begin
              st_d.cpu_done = 1'b1;
            end
            if (c_hit) begin
              st_d.lines[c_way][c_idx].valid               = 1'b0;
              st_d.lines[c_way][c_idx].longword_dirty_bits = 4'h0;
            end
          end else if (cpu_cmd.op == dcls_pkg::OP_WRITE && !cpu_cmd.page_cache_mode_field) begin
            st_d.mem_req   = 1'b1;
            st_d.mem_cmd   = dcls_pkg::MEM_WORD_WR;
            st_d.mem_addr  = cpu_cmd.addr;
            st_d.mem_wword = cpu_cmd.wdata;
            st_d.mem_be    = cpu_cmd.be;
            st_d.fsm       = dcls_pkg::S_WT;
            st_d.misses    = st_q.misses + dcls_pkg::CNT_STEP;
          end else begin
            st_d.misses   = st_q.misses + dcls_pkg::CNT_STEP;
            st_d.way      = v_way;
            st_d.mem_req  = 1'b1;
            st_d.mem_cmd  = dcls_pkg::MEM_LINE_RD;
            st_d.mem_addr = {cpu_cmd.addr[31:4], 4'h0};
            st_d.fsm      = dcls_pkg::S_FILL;
            if (!v_free && (|st_q.lines[v_way][c_idx].longword_dirty_bits)) begin
              st_d.pb_valid    = 1'b1;
              st_d.pb_lineaddr = {st_q.lines[v_way][c_idx].tag, c_idx};
              st_d.pb_data     = st_q.lines[v_way][c_idx].data;
            end
            st_d.lines[v_way][c_idx].valid               = 1'b0;
            st_d.lines[v_way][c_idx].longword_dirty_bits = 4'h0;
          end
        end
      end
      dcls_pkg::S_FILL: begin
        if (mem_ack) begin
          st_d.mem_req = 1'b0;
          st_d.cpu_done = 1'b1;
          st_d.lines[st_q.way][st_q.req.addr[5:4]].valid               = 1'b1;
          st_d.lines[st_q.way][st_q.req.addr[5:4]].longword_dirty_bits = 4'h0;
          st_d.lines[st_q.way][st_q.req.addr[5:4]].tag                 = st_q.req.addr[31:6];
          st_d.lines[st_q.way][st_q.req.addr[5:4]].data                = mem_rline;
          st_d.cpu_rdata = mem_rline[st_q.req.addr[3:2]*32 +: 32];
          if (st_q.req.op == dcls_pkg::OP_WRITE) begin
            st_d.lines[st_q.way][st_q.req.addr[5:4]].data[st_q.req.addr[3:2]*32 +: 32] =
              merge_word(mem_rline[st_q.req.addr[3:2]*32 +: 32], st_q.req.wdata, st_q.req.be);
            st_d.lines[st_q.way][st_q.req.addr[5:4]].longword_dirty_bits[st_q.req.addr[3:2]] = 1'b1;
          end
          if (st_d.pb_valid) begin
            st_d.mem_req   = 1'b1;
            st_d.mem_cmd   = dcls_pkg::MEM_LINE_WR;
            st_d.mem_addr  = {st_d.pb_lineaddr, 4'h0};
            st_d.mem_wline = st_d.pb_data;
            st_d.fsm       = dcls_pkg::S_PUSH;
          end else begin
            st_d.mem_cmd = dcls_pkg::MEM_IDLE;
            st_d.fsm     = dcls_pkg::S_IDLE;
          end
        end
      end
      dcls_pkg::S_PUSH: begin
        if (mem_ack) begin
          st_d.pb_valid = 1'b0;
          st_d.mem_req  = 1'b0;
          st_d.mem_cmd  = dcls_pkg::MEM_IDLE;
          st_d.fsm      = dcls_pkg::S_IDLE;
          st_d.cpu_done = st_q.req.op == dcls_pkg::OP_CACHE_PUSH;
        end
      end
      dcls_pkg::S_WT: begin
        if (mem_ack) begin
          st_d.mem_req  = 1'b0;
          st_d.mem_cmd  = dcls_pkg::MEM_IDLE;
          st_d.fsm      = dcls_pkg::S_IDLE;
          st_d.cpu_done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q      <= '0;
      st_q.lfsr <= dcls_pkg::LFSR_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign cpu_done    = st_q.cpu_done;
  assign cpu_rdata   = st_q.cpu_rdata;
  assign mem_req     = st_q.mem_req;
  assign mem_cmd     = st_q.mem_cmd;
  assign mem_addr    = st_q.mem_addr;
  assign mem_wline   = st_q.mem_wline;
  assign mem_wword   = st_q.mem_wword;
  assign mem_be      = st_q.mem_be;
  assign snp_done    = st_q.snp_done;
  assign snp_inhibit = st_q.snp_inhibit;
  assign snp_rline   = st_q.snp_rline;
  assign reg_rdata   = st_q.rd_data;

  // ***********************************************
  // assertions
  // ***********************************************
  fill_install_a: assert property (@(posedge sys_clk) disable iff (reset)
    (st_q.fsm == dcls_pkg::S_FILL && mem_ack) |=>
      st_q.lines[$past(st_q.way)][$past(st_q.req.addr[5:4])].valid &&
      st_q.lines[$past(st_q.way)][$past(st_q.req.addr[5:4])].tag == $past(st_q.req.addr[31:6]) && cpu_done)
    else $error("fill did not install line");

  victim_after_a: assert property (@(posedge sys_clk) disable iff (reset)
    (st_q.fsm == dcls_pkg::S_FILL && mem_ack && st_d.pb_valid) |=>
      st_q.fsm == dcls_pkg::S_PUSH && mem_req && mem_cmd == dcls_pkg::MEM_LINE_WR)
    else $error("victim not pushed after fill");

  pb_snoop_a: assert property (@(posedge sys_clk) disable iff (reset)
    (s_act && !s_hit && pb_hit && !snp_cmd.we) |=> snp_inhibit && snp_rline == $past(st_q.pb_data))
    else $error("push buffer not snooped");

  read_hit_a: assert property (@(posedge sys_clk) disable iff (reset)
    (cpu_taken && c_hit && cpu_cmd.op == dcls_pkg::OP_READ) |=>
      cpu_done && cpu_rdata == $past(c_word) && $stable(st_q.lines))
    else $error("read hit wrong");

  wt_miss_a: assert property (@(posedge sys_clk) disable iff (reset)
    (cpu_taken && !c_hit && cpu_cmd.op == dcls_pkg::OP_WRITE && !cpu_cmd.page_cache_mode_field) |=>
      st_q.fsm == dcls_pkg::S_WT && mem_cmd == dcls_pkg::MEM_WORD_WR && $stable(st_q.lines))
    else $error("write-through miss allocated");

  cb_hit_a: assert property (@(posedge sys_clk) disable iff (reset)
    (cpu_taken && c_hit && cpu_cmd.op == dcls_pkg::OP_WRITE && cpu_cmd.page_cache_mode_field) |=>
      st_q.lines[$past(c_way)][$past(c_idx)].longword_dirty_bits[$past(cpu_cmd.addr[3:2])] && cpu_done)
    else $error("copyback hit not dirty");

  inval_op_a: assert property (@(posedge sys_clk) disable iff (reset)
    (cpu_taken && c_hit && cpu_cmd.op == dcls_pkg::OP_CACHE_INVALIDATE) |=>
      !st_q.lines[$past(c_way)][$past(c_idx)].valid && !mem_req)
    else $error("invalidate failed");

  snoop_inv_a: assert property (@(posedge sys_clk) disable iff (reset)
    (s_act && s_hit && snp_cmd.code == dcls_pkg::SNP_INV) |=>
      !st_q.lines[$past(s_way)][$past(s_idx)].valid && snp_done)
    else $error("snoop did not invalidate");

  snoop_sink_a: assert property (@(posedge sys_clk) disable iff (reset)
    (s_act && s_hit && snp_cmd.we && snp_cmd.code == dcls_pkg::SNP_LEAVE && !snp_cmd.full_line &&
     (|st_q.lines[s_way][s_idx].longword_dirty_bits)) |=>
      snp_inhibit && st_q.lines[$past(s_way)][$past(s_idx)].longword_dirty_bits[$past(snp_cmd.addr[3:2])])
    else $error("snoop write not sunk");
endmodule : dcls_core

// ==== testbench/dcls_mem_model.sv ====
// dcls_mem_model: memory behind the cache, answers line reads, pushes and word writes
// assumes each request is held until mem_ack; every returned longword equals its own address
`timescale 1ns/100ps
module dcls_mem_model (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // request from the cache
  input  wire logic                mem_req,
  input  wire dcls_pkg::dcls_mem_t mem_cmd,
  input  wire logic [31:0]         mem_addr,
  input  wire logic [127:0]        mem_wline,
  input  wire logic [31:0]         mem_wword,
  input  wire logic                slow,
  // answer
  output logic                     mem_ack,
  output logic [127:0]             mem_rline,
  // record of finished transfers
  output int                       n_rd,
  output int                       n_lwr,
  output int                       n_wwr,
  output logic [31:0]              last_addr,
  output logic [31:0]              last_word,
  output logic [127:0]             last_line
);
  logic [2:0]  wait_q;
  logic [31:0] line_a;

  assign line_a = {mem_addr[31:4], 4'h0};

  // slow mode holds the answer back four cycles; outside the ack cycle the data lines keep changing
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wait_q    <= 3'h0;
      mem_ack   <= 1'h0;
      mem_rline <= '0;
      n_rd      <= 0;
      n_lwr     <= 0;
      n_wwr     <= 0;
      last_addr <= 32'h0;
      last_word <= 32'h0;
      last_line <= '0;
    end else if (mem_req && !mem_ack && wait_q >= (slow ? 3'h4 : 3'h0)) begin
      mem_ack   <= 1'h1;
      mem_rline <= {line_a + 32'hC, line_a + 32'h8, line_a + 32'h4, line_a};
      wait_q    <= 3'h0;
      last_addr <= mem_addr;
      if (mem_cmd == dcls_pkg::MEM_LINE_RD) n_rd <= n_rd + 1;
      if (mem_cmd == dcls_pkg::MEM_LINE_WR) n_lwr <= n_lwr + 1;
      if (mem_cmd == dcls_pkg::MEM_LINE_WR) last_line <= mem_wline;
      if (mem_cmd == dcls_pkg::MEM_WORD_WR) n_wwr <= n_wwr + 1;
      if (mem_cmd == dcls_pkg::MEM_WORD_WR) last_word <= mem_wword;
    end else begin
      mem_ack   <= 1'h0;
      mem_rline <= ~mem_rline;
      wait_q    <= (mem_req && !mem_ack) ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule : dcls_mem_model

// ==== testbench/tb_top.sv ====
// tb_top: self-checking bench for dcls_core against the memory model
// assumes dcls_pkg and dcls_mem_model are compiled first
`timescale 1ns/100ps
module tb_top;
  localparam dcls_pkg::dcls_op_t RD  = dcls_pkg::OP_READ;
  localparam dcls_pkg::dcls_op_t WR  = dcls_pkg::OP_WRITE;
  localparam dcls_pkg::dcls_op_t INV = dcls_pkg::OP_CACHE_INVALIDATE;
  localparam dcls_pkg::dcls_op_t PSH = dcls_pkg::OP_CACHE_PUSH;
  localparam logic [1:0]  LV = dcls_pkg::SNP_LEAVE;
  localparam logic [1:0]  IV = dcls_pkg::SNP_INV;
  localparam logic [31:0] A = 32'h1000, B = 32'h2010, C = 32'h3020, D = 32'h4030, E = 32'h5020;

  logic                    sys_clk   = 1'h0;
  logic                    reset     = 1'h1;
  logic                    cpu_req   = 1'h0;
  logic                    snp_valid = 1'h0;
  logic                    reg_wr    = 1'h0;
  logic                    reg_rd    = 1'h0;
  logic [7:0]              reg_addr  = 8'h0;
  logic [31:0]             reg_wdata = 32'h0;
  dcls_pkg::dcls_cpu_req_t cpu_cmd   = '0;
  dcls_pkg::dcls_snp_req_t snp_cmd   = '0;
  logic                    slow      = 1'h0;
  logic                    peek      = 1'h0;
  logic                    cpu_ready, cpu_done, mem_req, mem_ack, snp_done, snp_inhibit;
  logic [31:0]             cpu_rdata, mem_addr, mem_wword, reg_rdata, last_addr, last_word;
  logic [127:0]            mem_wline, mem_rline, snp_rline, last_line;
  logic [3:0]              mem_be;
  dcls_pkg::dcls_mem_t     mem_cmd;
  int                      n_rd, n_lwr, n_wwr;
  int                      n_mismatch  = 0;
  int                      comparisons = 0;

  always #5 sys_clk = ~sys_clk;

  dcls_core dcls_core_inst (.sys_clk, .reset, .cpu_req, .cpu_cmd, .cpu_ready, .cpu_done, .cpu_rdata, .mem_req,
    .mem_cmd, .mem_addr, .mem_wline, .mem_wword, .mem_be, .mem_ack, .mem_rline, .snp_valid, .snp_cmd, .snp_done,
    .snp_inhibit, .snp_rline, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  dcls_mem_model dcls_mem_model_inst (.sys_clk, .reset, .mem_req, .mem_cmd, .mem_addr, .mem_wline, .mem_wword,
    .slow, .mem_ack, .mem_rline, .n_rd, .n_lwr, .n_wwr, .last_addr, .last_word, .last_line);

  // ***********************************************
  // access tasks
  // ***********************************************
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'h0;
    @(negedge sys_clk);
    chk("register read", reg_rdata, exp);
  endtask : reg_read

  // waits on cpu_ready (0) or cpu_done (1), bounded
  task automatic wait_for(input int which);
    for (int i = 0; i < 200; i++) begin
      @(negedge sys_clk);
      if ((which == 0 ? cpu_ready : cpu_done) === 1'h1) return;
    end
    n_mismatch++;
  endtask : wait_for

  task automatic snoop(input logic w, input logic [1:0] c, input logic f, input logic [31:0] a,
                       input logic [31:0] wd, input logic inh, input logic [31:0] ew);
    @(posedge sys_clk);
    snp_valid <= 1'h1;
    snp_cmd   <= '{w, c, f, a, wd, 4'hF};
    @(posedge sys_clk);
    snp_valid <= 1'h0;
    @(negedge sys_clk);
    chk("snoop answer", {snp_done, snp_inhibit}, {1'h1, inh});
    if (inh && !w) chk("snoop line", snp_rline[32*a[3:2] +: 32], ew);
  endtask : snoop

  task automatic cpu_op(input dcls_pkg::dcls_op_t o, input logic cb, input logic [31:0] a, input logic [31:0] wd,
                        input logic [31:0] er, input int drd, input int dlw, input int dww);
    int r0;
    int l0;
    int w0;
    r0 = n_rd;
    l0 = n_lwr;
    w0 = n_wwr;
    @(posedge sys_clk);
    cpu_req <= 1'h1;
    cpu_cmd <= '{o, cb, a, wd, 4'hF};
    wait_for(0);
    @(posedge sys_clk);
    cpu_req <= 1'h0;
    wait_for(1);
    if (o == RD) chk("read data", cpu_rdata, er);
    if (peek) begin
      chk("fill before push", n_rd - r0, 1);
      chk("push pending", {mem_req, mem_cmd, n_lwr - l0}, {1'h1, dcls_pkg::MEM_LINE_WR, 32'h0});
      snoop(1'h0, LV, 1'h0, mem_addr, 32'h0, 1'h1, 32'hD0000000 | ((mem_addr - E) >> 6));
    end
    wait_for(0);
    chk("line reads", n_rd - r0, drd);
    chk("line writes", n_lwr - l0, dlw);
    chk("word writes", n_wwr - w0, dww);
  endtask : cpu_op

  // ***********************************************
  // tests
  // ***********************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'h0;
    reg_read(dcls_pkg::REG_SEED, 32'hB4);
    reg_write(dcls_pkg::REG_SEED, 32'h0);
    reg_read(dcls_pkg::REG_SEED, 32'hB4);
    reg_write(8'h10, 32'hFFFFFFFF);
    reg_read(8'h10, 32'h0);
    reg_read(dcls_pkg::REG_STATUS, 32'h0);
    cpu_op(RD, 1'h1, A + 32'h4, 32'h0, A + 32'h4, 1, 0, 0);
    cpu_op(RD, 1'h1, A + 32'h8, 32'h0, A + 32'h8, 0, 0, 0);
    reg_read(dcls_pkg::REG_HITS, 32'h1);
    reg_read(dcls_pkg::REG_MISSES, 32'h1);
    cpu_op(WR, 1'h1, A + 32'h4, 32'hCAFE0001, 32'h0, 0, 0, 0);
    cpu_op(WR, 1'h1, A + 32'h4, 32'hCAFE0002, 32'h0, 0, 0, 0);
    snoop(1'h0, LV, 1'h0, A + 32'h4, 32'h0, 1'h1, 32'hCAFE0002);
    snoop(1'h0, IV, 1'h0, A + 32'h8, 32'h0, 1'h1, A + 32'h8);
    cpu_op(RD, 1'h1, A + 32'h4, 32'h0, A + 32'h4, 1, 0, 0);
    snoop(1'h0, LV, 1'h0, A, 32'h0, 1'h0, 32'h0);
    cpu_op(RD, 1'h1, A, 32'h0, A, 0, 0, 0);
    snoop(1'h0, IV, 1'h0, A, 32'h0, 1'h0, 32'h0);
    cpu_op(RD, 1'h1, A, 32'h0, A, 1, 0, 0);
    snoop(1'h1, LV, 1'h0, A, 32'h0, 1'h0, 32'h0);
    cpu_op(RD, 1'h1, A, 32'h0, A, 1, 0, 0);
    cpu_op(WR, 1'h0, B, 32'h12345678, 32'h0, 0, 0, 1);
    chk("word write", {last_addr, last_word, mem_be}, {B, 32'h12345678, 4'hF});
    cpu_op(RD, 1'h1, B, 32'h0, B, 1, 0, 0);
    cpu_op(WR, 1'h0, B + 32'h4, 32'h9ABCDEF0, 32'h0, 0, 0, 1);
    cpu_op(RD, 1'h1, B + 32'h4, 32'h0, 32'h9ABCDEF0, 0, 0, 0);
    snoop(1'h0, LV, 1'h0, B, 32'h0, 1'h0, 32'h0);
    cpu_op(WR, 1'h1, C + 32'h8, 32'h55AA33CC, 32'h0, 1, 0, 0);
    snoop(1'h0, LV, 1'h0, C + 32'h8, 32'h0, 1'h1, 32'h55AA33CC);
    snoop(1'h0, LV, 1'h0, C + 32'h4, 32'h0, 1'h1, C + 32'h4);
    snoop(1'h1, LV, 1'h0, C + 32'h4, 32'h77770000, 1'h1, 32'h0);
    snoop(1'h0, LV, 1'h0, C + 32'h4, 32'h0, 1'h1, 32'h77770000);
    snoop(1'h1, LV, 1'h1, C, 32'h0, 1'h0, 32'h0);
    snoop(1'h0, LV, 1'h0, C, 32'h0, 1'h0, 32'h0);
    cpu_op(WR, 1'h1, D, 32'h11, 32'h0, 1, 0, 0);
    cpu_op(INV, 1'h1, D, 32'h0, 32'h0, 0, 0, 0);
    snoop(1'h0, LV, 1'h0, D, 32'h0, 1'h0, 32'h0);
    cpu_op(WR, 1'h1, D, 32'h22, 32'h0, 1, 0, 0);
    cpu_op(PSH, 1'h1, D, 32'h0, 32'h0, 0, 1, 0);
    chk("pushed line", {last_addr, last_line[31:0]}, {D, 32'h22});
    snoop(1'h0, LV, 1'h0, D, 32'h0, 1'h0, 32'h0);
    cpu_op(PSH, 1'h1, D, 32'h0, 32'h0, 0, 0, 0);
    cpu_op(WR, 1'h1, D, 32'h33, 32'h0, 1, 0, 0);
    snoop(1'h1, IV, 1'h0, D, 32'h0, 1'h0, 32'h0);
    snoop(1'h0, LV, 1'h0, D, 32'h0, 1'h0, 32'h0);
    for (int k = 0; k < 4; k++) begin
      cpu_op(WR, 1'h1, E + 32'h40 * k, 32'hD0000000 | k, 32'h0, 1, 0, 0);
    end
    slow = 1'h1;
    peek = 1'h1;
    cpu_op(RD, 1'h1, E + 32'h100, 32'h0, E + 32'h100, 1, 1, 0);
    peek = 1'h0;
    chk("victim line", last_line[31:0], 32'hD0000000 | ((last_addr - E) >> 6));
    snoop(1'h0, LV, 1'h0, last_addr, 32'h0, 1'h0, 32'h0);
    snoop(1'h0, LV, 1'h0, E + 32'h100, 32'h0, 1'h0, 32'h0);
    test_done();
  end

  // watchdog: the tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
endmodule : tb_top
